// ### uart_fmt_pkg.sv
// Register map, field layout and timing constants of the serial port block
package uart_fmt_pkg;
	// Byte addresses on the register bus
	localparam logic [7:0] ADDR_MODE     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_BAUD     = 8'h08;
	localparam logic [7:0] ADDR_TXDATA   = 8'h0C;
	localparam logic [7:0] ADDR_RXDATA   = 8'h10;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

	// Mode register fields
	localparam int MODE_STOP_BIT   = 0;
	localparam int MODE_PDSEL_LSB  = 1;
	localparam int MODE_BAUD_HI    = 3;
	localparam int MODE_RX_INV     = 4;

	// Status/control register fields
	localparam int ST_RXDA    = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_FRAME   = 2;
	localparam int ST_PARITY  = 3;
	localparam int ST_RX_LINE_IDLE   = 4;
	localparam int ST_TX_SHIFT_EMPTY    = 8;
	localparam int ST_TXBF    = 9;
	localparam int ST_BREAK   = 11;

	// Interrupt status bits
	localparam int IRQ_RX_DONE = 0;
	localparam int IRQ_TX_DONE = 1;
	localparam int IRQ_ERROR   = 2;
	localparam int IRQ_W       = 3;

	localparam logic [15:0] MODE_RESET = 16'h0000;
	localparam logic [15:0] BAUD_RESET = 16'h0000;

	// Sample clocks per bit, and zero data bits in a break frame
	localparam logic [4:0] OVS_STD  = 5'd16;
	localparam logic [4:0] OVS_FAST = 5'd4;
	localparam int         BREAK_ZEROS = 12;

	typedef enum logic [1:0] {
		PD_8N = 2'b00,
		PD_8E = 2'b01,
		PD_8O = 2'b10,
		PD_9N = 2'b11
	} parity_data_t;
endpackage

// ### uart_fmt_if.sv
// Signals shared by the register core, transmitter and receiver
interface uart_fmt_if;
	import uart_fmt_pkg::*;
	logic         sample_tick;
	logic [4:0]   ovs;
	parity_data_t pdsel;
	logic         two_stop;
	logic         rx_inv;
	logic         tx_start;
	logic         tx_break;
	logic [8:0]   tx_data;
	logic         tx_busy;
	logic         tx_done;
	logic         rx_valid;
	logic [8:0]   rx_data;
	logic         rx_perr;
	logic         rx_ferr;
	logic         rx_idle;

	modport core (output sample_tick, ovs, pdsel, two_stop, rx_inv, tx_start, tx_break,
		tx_data, input tx_busy, tx_done, rx_valid, rx_data, rx_perr, rx_ferr, rx_idle);
	modport tx (input sample_tick, ovs, pdsel, two_stop, tx_start, tx_break, tx_data,
		output tx_busy, tx_done);
	modport rx (input sample_tick, ovs, pdsel, rx_inv,
		output rx_valid, rx_data, rx_perr, rx_ferr, rx_idle);
endinterface

// ### uart_fmt_tx.sv
// Serial transmitter: start, data, optional parity, one or two stops, break
module uart_fmt_tx
	import uart_fmt_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_srst,
	uart_fmt_if.tx    bus,
	output logic      o_tx_q
);
	typedef enum logic [2:0] {S_IDLE, S_SYNC, S_START, S_DATA, S_PAR, S_STOP} tx_state_t;
	tx_state_t  st_q;
	logic [4:0] tick_q;
	logic [3:0] bit_q;
	logic [3:0] nbits_q;
	logic [8:0] sh_q;
	logic       par_q;
	logic       brk_q;
	logic       stop2_q;
	wire        bit_end = bus.sample_tick && (tick_q == bus.ovs - 5'd1);

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_q     <= S_IDLE;
			tick_q   <= '0;
			bit_q    <= '0;
			nbits_q  <= '0;
			sh_q     <= '0;
			par_q    <= 1'b0;
			brk_q    <= 1'b0;
			stop2_q  <= 1'b0;
			o_tx_q   <= 1'b1;
			bus.tx_done <= 1'b0;
		end else begin
			bus.tx_done <= 1'b0;
			if (bus.sample_tick && st_q != S_IDLE)
				tick_q <= bit_end ? 5'd0 : tick_q + 5'd1;
			unique case (st_q)
				S_IDLE: begin
					o_tx_q <= 1'b1;
					if (bus.tx_start) begin
						st_q    <= S_SYNC;
						tick_q  <= '0;
						brk_q   <= bus.tx_break;
						stop2_q <= bus.two_stop;
						// 9 bits only for 9-bit mode
						nbits_q <= bus.tx_break ? 4'(BREAK_ZEROS) :
							(bus.pdsel == PD_9N ? 4'd9 : 4'd8);
						sh_q    <= bus.tx_break ? 9'h000 : bus.tx_data;
						par_q   <= (bus.pdsel == PD_8O) ^ (^bus.tx_data[7:0]);
					end
				end
				// Start edge waits for a sample tick, else the start bit comes out short
				S_SYNC: if (bus.sample_tick) begin
					st_q   <= S_START;
					tick_q <= '0;
					o_tx_q <= 1'b0;
				end
				S_START: if (bit_end) begin
					st_q   <= S_DATA;
					bit_q  <= '0;
					o_tx_q <= sh_q[0];
					sh_q   <= sh_q >> 1;
				end
				S_DATA: if (bit_end) begin
					if (bit_q == nbits_q - 4'd1) begin
						if (!brk_q && (bus.pdsel == PD_8E || bus.pdsel == PD_8O)) begin
							st_q   <= S_PAR;
							o_tx_q <= par_q;
						end else begin
							st_q   <= S_STOP;
							o_tx_q <= 1'b1;
						end
						bit_q <= '0;
					end else begin
						bit_q  <= bit_q + 4'd1;
						o_tx_q <= sh_q[0];
						sh_q   <= sh_q >> 1;
					end
				end
				S_PAR: if (bit_end) begin
					st_q   <= S_STOP;
					o_tx_q <= 1'b1;
				end
				S_STOP: if (bit_end) begin
					// Break frames carry a single stop bit
					if (stop2_q && !brk_q && bit_q == 4'd0) begin
						bit_q <= 4'd1;
					end else begin
						st_q        <= S_IDLE;
						bus.tx_done <= 1'b1;
					end
				end
			endcase
		end
	end

	assign bus.tx_busy = (st_q != S_IDLE);
endmodule

// ### uart_fmt_rx.sv
// Serial receiver with idle polarity select and mid-bit sampling
module uart_fmt_rx
	import uart_fmt_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_srst,
	input  wire logic i_rx_pin,
	uart_fmt_if.rx    bus
);
	typedef enum logic [2:0] {R_IDLE, R_START, R_DATA, R_PAR, R_STOP} rx_state_t;
	rx_state_t  st_q;
	logic [4:0] tick_q;
	logic [3:0] bit_q;
	logic [8:0] sh_q;
	logic       par_q;
	wire        line = i_rx_pin ^ bus.rx_inv;
	wire        mid  = bus.sample_tick && (tick_q == (bus.ovs >> 1) - 5'd1);
	wire        bend = bus.sample_tick && (tick_q == bus.ovs - 5'd1);
	wire        nine = (bus.pdsel == PD_9N);
	wire        has_par = (bus.pdsel == PD_8E || bus.pdsel == PD_8O);

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_q         <= R_IDLE;
			tick_q       <= '0;
			bit_q        <= '0;
			sh_q         <= '0;
			par_q        <= 1'b0;
			bus.rx_valid <= 1'b0;
			bus.rx_data  <= '0;
			bus.rx_perr  <= 1'b0;
			bus.rx_ferr  <= 1'b0;
		end else begin
			bus.rx_valid <= 1'b0;
			if (bus.sample_tick && st_q != R_IDLE)
				tick_q <= bend ? 5'd0 : tick_q + 5'd1;
			unique case (st_q)
				R_IDLE: if (!line) begin
					st_q   <= R_START;
					tick_q <= '0;
				end
				R_START: if (mid) begin
					// Glitch shorter than half a bit returns to idle
					if (line)
						st_q <= R_IDLE;
				end else if (bend) begin
					st_q  <= R_DATA;
					bit_q <= '0;
				end
				R_DATA: if (mid) begin
					sh_q <= nine ? {line, sh_q[8:1]} : {1'b0, line, sh_q[7:1]};
				end else if (bend) begin
					if (bit_q == (nine ? 4'd8 : 4'd7))
						st_q <= has_par ? R_PAR : R_STOP;
					bit_q <= bit_q + 4'd1;
				end
				R_PAR: if (mid) begin
					par_q <= line ^ (^sh_q[7:0]) ^ (bus.pdsel == PD_8O);
				end else if (bend) begin
					st_q <= R_STOP;
				end
				R_STOP: if (mid) begin
					// One stop bit checked; a second acts as idle time
					st_q         <= R_IDLE;
					bus.rx_valid <= 1'b1;
					bus.rx_data  <= sh_q;
					bus.rx_perr  <= has_par && par_q;
					bus.rx_ferr  <= !line;
				end
			endcase
		end
	end

	assign bus.rx_idle = (st_q == R_IDLE);
endmodule

// ### uart_fmt_top.sv
// Serial port with frame-format configuration, status word and AHB-Lite registers
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.

module uart_fmt_top
	import uart_fmt_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              i_sys_clk,
	input  wire logic              i_srst,
	// AHB-Lite slave
	input  wire logic              i_hsel,
	input  wire logic [ADDR_W-1:0] i_haddr,
	input  wire logic [1:0]        i_htrans,
	input  wire logic              i_hwrite,
	input  wire logic [2:0]        i_hsize,
	input  wire logic [31:0]       i_hwdata,
	input  wire logic              i_hready,
	output logic [31:0]            o_hrdata,
	output logic                   o_hreadyout,
	output logic                   o_hresp,
	// Serial line
	input  wire logic              i_serial_rx_pin,
	output logic                   o_serial_tx_pin,
	// Interrupt
	output logic                   o_irq
);
	// Narrower addresses would alias the register map
	if (ADDR_W < 5 || ADDR_W > 32) begin
		$error("ADDR_W out of range");
	end

	uart_fmt_if lnk ();

	// Software-visible state, break busy flag and baud generator
	logic [15:0]        mode_q;
	logic [15:0]        baud_q;
	logic               brk_req_q;
	logic               brk_busy_q;
	logic               overrun_q;
	logic               rxda_q;
	logic [8:0]         rxbuf_q;
	logic               perr_q;
	logic               ferr_q;
	logic [8:0]         txbuf_q;
	logic               txbf_q;
	logic               tx_shift_empty_q;
	logic [IRQ_W-1:0]   irq_stat_q;
	logic [IRQ_W-1:0]   irq_mask_q;
	logic [15:0]        brg_cnt_q;
	logic               tick_q;

	// AHB address phase capture
	logic               wr_pend_q;
	logic               rd_take;
	logic [7:0]         addr_q;
	wire                xfer = i_hsel && i_hready && i_htrans[1];
	wire                wr   = wr_pend_q;
	wire  [15:0]        wd   = i_hwdata[15:0];

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			wr_pend_q   <= 1'b0;
			addr_q      <= '0;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			wr_pend_q   <= xfer && i_hwrite;
			if (xfer)
				addr_q <= 8'(i_haddr);
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
	end

	// Read data registered in the address phase, shown in the data phase
	assign rd_take = xfer && !i_hwrite;
	wire [15:0] status_word = {4'h0, brk_req_q, 1'b0, txbf_q, tx_shift_empty_q, 3'h0, lnk.rx_idle,
		perr_q, ferr_q, overrun_q, rxda_q};

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			o_hrdata <= '0;
		end else if (rd_take) begin
			unique case (8'(i_haddr))
				ADDR_MODE:     o_hrdata <= {16'h0000, mode_q};
				ADDR_STATUS:   o_hrdata <= {16'h0000, status_word};
				ADDR_BAUD:     o_hrdata <= {16'h0000, baud_q};
				ADDR_RXDATA:   o_hrdata <= {23'h00_0000, rxbuf_q};
				ADDR_IRQ_STAT: o_hrdata <= {29'h0000_0000, irq_stat_q};
				ADDR_IRQ_MASK: o_hrdata <= {29'h0000_0000, irq_mask_q};
				default:       o_hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			mode_q     <= MODE_RESET;
			baud_q     <= BAUD_RESET;
			irq_mask_q <= '0;
		end else if (wr) begin
			if (addr_q == ADDR_MODE)
				mode_q <= {11'h000, wd[4:0]};
			if (addr_q == ADDR_BAUD)
				baud_q <= wd;
			if (addr_q == ADDR_IRQ_MASK)
				irq_mask_q <= wd[IRQ_W-1:0];
		end
	end

	// Baud generator: one sample tick every baud_q+1 clocks
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			brg_cnt_q <= '0;
			tick_q    <= 1'b0;
		end else if (brg_cnt_q >= baud_q) begin
			brg_cnt_q <= '0;
			tick_q    <= 1'b1;
		end else begin
			brg_cnt_q <= brg_cnt_q + 16'd1;
			tick_q    <= 1'b0;
		end
	end

	assign lnk.sample_tick = tick_q;
	assign lnk.ovs      = mode_q[MODE_BAUD_HI] ? OVS_FAST : OVS_STD;
	assign lnk.pdsel    = parity_data_t'(mode_q[MODE_PDSEL_LSB +: 2]);
	assign lnk.two_stop = mode_q[MODE_STOP_BIT];
	assign lnk.rx_inv   = mode_q[MODE_RX_INV];

	// Transmit buffer and break request; break waits for the shifter to go idle
	wire txd_wr = wr && addr_q == ADDR_TXDATA;
	wire brk_go = brk_req_q && !brk_busy_q && !lnk.tx_busy;
	wire tx_go  = !brk_go && txbf_q && !lnk.tx_busy && !brk_busy_q;
	assign lnk.tx_start = brk_go || tx_go;
	assign lnk.tx_break = brk_go;
	assign lnk.tx_data  = txbuf_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			brk_req_q  <= 1'b0;
			brk_busy_q <= 1'b0;
		end else begin
			if (brk_go)
				brk_busy_q <= 1'b1;
			if (brk_busy_q && lnk.tx_done) begin
				brk_busy_q <= 1'b0;
				brk_req_q  <= 1'b0;
			end else if (wr && addr_q == ADDR_STATUS && wd[ST_BREAK]) begin
				brk_req_q  <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			txbuf_q <= '0;
			txbf_q  <= 1'b0;
			tx_shift_empty_q  <= 1'b1;
		end else begin
			if (txd_wr && !txbf_q) begin
				txbuf_q <= wd[8:0];
				txbf_q  <= 1'b1;
			end else if (tx_go) begin
				txbf_q  <= 1'b0;
			end
			tx_shift_empty_q <= !(lnk.tx_start || lnk.tx_busy || txbf_q || txd_wr);
		end
	end

	// Receive holding register and error flags
	wire rxd_rd = rd_take && 8'(i_haddr) == ADDR_RXDATA;
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			rxbuf_q   <= '0;
			rxda_q    <= 1'b0;
			perr_q    <= 1'b0;
			ferr_q    <= 1'b0;
			overrun_q <= 1'b0;
		end else begin
			if (lnk.rx_valid && !rxda_q) begin
				rxbuf_q <= lnk.rx_data;
				rxda_q  <= 1'b1;
				perr_q  <= lnk.rx_perr;
				ferr_q  <= lnk.rx_ferr;
			end else if (rxd_rd) begin
				rxda_q  <= 1'b0;
			end
			// Set wins over a software clear; writing one never sets it
			if (lnk.rx_valid && rxda_q)
				overrun_q <= 1'b1;
			else if (wr && addr_q == ADDR_STATUS && !wd[ST_OVERRUN])
				overrun_q <= 1'b0;
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	wire [IRQ_W-1:0] irq_set = {lnk.rx_valid && (lnk.rx_perr || lnk.rx_ferr || rxda_q),
		lnk.tx_done, lnk.rx_valid};
	wire [IRQ_W-1:0] irq_clr = (wr && addr_q == ADDR_IRQ_STAT) ? wd[IRQ_W-1:0] : '0;
	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			irq_stat_q <= '0;
			o_irq      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
			o_irq      <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
		end
	end

	uart_fmt_tx u_tx (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.bus       (lnk.tx),
		.o_tx_q    (o_serial_tx_pin)
	);

	uart_fmt_rx u_rx (
		.i_sys_clk (i_sys_clk),
		.i_srst    (i_srst),
		.i_rx_pin  (i_serial_rx_pin),
		.bus       (lnk.rx)
	);
endmodule

// ### uart_fmt_properties.sv
// Port-level checks of the serial port block
module uart_fmt_properties
	import uart_fmt_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic              i_sys_clk,
	input wire logic              i_srst,
	input wire logic              i_hsel,
	input wire logic [ADDR_W-1:0] i_haddr,
	input wire logic [1:0]        i_htrans,
	input wire logic              i_hwrite,
	input wire logic [2:0]        i_hsize,
	input wire logic [31:0]       i_hwdata,
	input wire logic              i_hready,
	input wire logic [31:0]       o_hrdata,
	input wire logic              o_hreadyout,
	input wire logic              o_hresp,
	input wire logic              i_serial_rx_pin,
	input wire logic              o_serial_tx_pin,
	input wire logic              o_irq
);
	logic              wr_q;
	logic              rd_q;
	logic [ADDR_W-1:0] adr_q;
	logic [15:0]       mode_q;
	logic [15:0]       baud_q;
	logic [23:0]       low_q;
	logic [23:0]       bitc;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);

	// Shadow of the timing registers, so bit length is known here
	assign bitc = (mode_q[MODE_BAUD_HI] ? 24'h00_0004 : 24'h00_0010) * (24'(baud_q) + 24'h00_0001);

	always_ff @(posedge i_sys_clk) begin
		if (i_srst) begin
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
			mode_q <= MODE_RESET;
			baud_q <= BAUD_RESET;
		end else begin
			wr_q  <= i_hsel && i_hready && i_htrans[1] && i_hwrite;
			rd_q  <= i_hsel && i_hready && i_htrans[1] && !i_hwrite;
			adr_q <= i_haddr;
			if (wr_q && adr_q == ADDR_MODE)
				mode_q <= i_hwdata[15:0];
			if (wr_q && adr_q == ADDR_BAUD)
				baud_q <= i_hwdata[15:0];
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_srst || o_serial_tx_pin)
			low_q <= 24'h00_0000;
		else
			low_q <= low_q + 24'h00_0001;
	end

	ready_okay_a: assert property (o_hreadyout && !o_hresp)
		else $error("bus answer not ready or not okay");
	tx_reset_idle_a: assert property ($fell(i_srst) |-> o_serial_tx_pin && !o_irq)
		else $error("line or interrupt not idle after reset");
	bit_time_a: assert property ($rose(o_serial_tx_pin) |-> (low_q % bitc) == 0)
		else $error("low run not whole bit times");
	break_len_a: assert property ($rose(o_serial_tx_pin) && low_q > 10 * bitc |->
		low_q == 13 * bitc)
		else $error("break low run has wrong length");
	status_zero_a: assert property (rd_q && adr_q == ADDR_STATUS |->
		o_hrdata[31:12] == 20'h0_0000 && o_hrdata[7:5] == 3'h0 && !o_hrdata[10])
		else $error("unused status bits not zero");
	unmapped_zero_a: assert property (rd_q && adr_q > ADDR_IRQ_MASK |-> o_hrdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	mask_off_a: assert property (wr_q && adr_q == ADDR_IRQ_MASK && i_hwdata[IRQ_W-1:0] == 3'h0
		|=> ##1 !o_irq)
		else $error("interrupt stays high with all masked");
endmodule

bind uart_fmt_top uart_fmt_properties #(.ADDR_W(ADDR_W)) u_props (
	.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_hsel(i_hsel), .i_haddr(i_haddr),
	.i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
	.i_hready(i_hready), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
	.i_serial_rx_pin(i_serial_rx_pin), .o_serial_tx_pin(o_serial_tx_pin), .o_irq(o_irq)
);

// ### uart_line_partner.sv
// Far-end serial line model: drives the receive line, captures sent frames
module uart_line_partner (
	// Clock
	input  wire logic        i_clk,
	// Line
	input  wire logic        i_tx,
	output logic             o_rx,
	// Bench control
	input  wire logic [15:0] i_bit_clks,
	input  wire logic [4:0]  i_nbits,
	input  wire logic        i_inv,
	// Captured frame
	output logic             o_done,
	output logic [15:0]      o_frame
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        rx_bit = 1'b1;
	logic [15:0] f;

	assign o_rx = rx_bit ^ i_inv;

	// Mid-bit sampling, as a real receiver would
	initial begin
		o_done  = 1'b0;
		o_frame = 16'hffff;
		forever begin
			@(negedge i_tx);
			repeat (i_bit_clks / 2) @(posedge i_clk);
			f = 16'hffff;
			for (int i = 0; i < i_nbits; i++) begin
				f[i] = i_tx;
				if (i < i_nbits - 1)
					repeat (i_bit_clks) @(posedge i_clk);
			end
			o_frame <= f;
			o_done  <= 1'b1;
			@(posedge i_clk);
			o_done <= 1'b0;
		end
	end

	// Frame ends on its stop bits, so the line is left idle
	task automatic send(input logic [15:0] fr, input int n);
		for (int i = 0; i < n; i++) begin
			rx_bit <= fr[i];
			repeat (i_bit_clks) @(posedge i_clk);
		end
	endtask
endmodule

// ### uart_frame_format_and_status_tb_top.sv
// Self-checking bench of the serial port block
module uart_frame_format_and_status_tb_top
	import uart_fmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        i_sys_clk, i_srst, hsel, hwrite, hready, hresp, irq, tx, rx, pdone, inv;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [31:0] hwdata, hrdata, rd_v;
	logic [15:0] bit_clks, pframe;
	logic [4:0]  nbits;
	int          n_errors, tests_run, cyc;
	logic [31:0] rq[$];
	logic [15:0] fq[$];
	event        rd_e;

	uart_fmt_top u_dut (
		.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
		.i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
		.i_serial_rx_pin(rx), .o_serial_tx_pin(tx), .o_irq(irq)
	);
	uart_line_partner u_partner (
		.i_clk(i_sys_clk), .i_tx(tx), .o_rx(rx), .i_bit_clks(bit_clks), .i_nbits(nbits),
		.i_inv(inv), .o_done(pdone), .o_frame(pframe)
	);

	initial begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	task finish_test;
		if (fq.size() != 0 || rq.size() != 0) begin
			$display("Error at %0t: %0d frames never seen", $time, fq.size());
			n_errors++;
		end
		$display("Mismatches %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			$display("Error at %0t: got %h expected %h", $time, g, e);
			n_errors++;
		end
	endtask

	// Start, LSB-first data, parity, stops; unused upper bits read as idle
	function automatic logic [15:0] frame(input logic [8:0] d, input logic [1:0] pd,
			input logic two, output int n);
		logic [15:0] fr;
		int          k;
		fr = 16'hfffe;
		k = (pd == 2'b11) ? 9 : 8;
		for (int i = 0; i < k; i++)
			fr[1 + i] = d[i];
		if (pd == 2'b01)
			fr[9] = ^d[7:0];
		if (pd == 2'b10)
			fr[9] = ~^d[7:0];
		n = 2 + k + int'(pd == 2'b01 || pd == 2'b10) + int'(two);
		return fr;
	endfunction

	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= a;
		hwrite <= w;
		do @(posedge i_sys_clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge i_sys_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask

	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0000_0000, x);
		rq.push_back(e);
		rd_v = x;
		->rd_e;
	endtask

	task wait_tx;
		for (int i = 0; i < 20000 && fq.size() != 0; i++)
			@(posedge i_sys_clk);
		repeat (2 * bit_clks) @(posedge i_sys_clk);
	endtask

	task wait_rx;
		logic [31:0] x;
		x = 32'h0000_0000;
		for (int i = 0; i < 400 && x[ST_RXDA] !== 1'b1; i++)
			xfer(1'b0, ADDR_STATUS, 32'h0000_0000, x);
	endtask

	initial forever begin
		@(rd_e);
		chk(rd_v, rq.pop_front());
	end

	always @(posedge i_sys_clk) begin
		if (pdone === 1'b1) begin
			if (fq.size() == 0)
				chk(32'h0000_0001, 32'h0000_0000);
			else
				chk(32'(pframe), 32'(fq.pop_front()));
		end
	end

	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_errors++;
			finish_test;
		end
	end

	initial begin
		logic [31:0] d;
		logic [15:0] f;
		logic [1:0]  pd;
		logic        hs, two;
		int          n;
		i_srst = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 8'h00;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		inv = 1'b0;
		bit_clks = 16'h0020;
		nbits = 5'h0a;
		void'($urandom(32'hc0e9_65fb));
		repeat (6) @(posedge i_sys_clk);
		i_srst <= 1'b0;
		@(posedge i_sys_clk);
		rd_chk(ADDR_STATUS, 32'h0000_0110);
		rd_chk(8'h1c, 32'h0000_0000);
		wr(ADDR_BAUD, 32'h0000_0001);
		for (int c = 0; c < 8; c++) begin
			pd = 2'(c >> 1);
			two = c[0];
			hs = c[0] ^ c[1];
			wr(ADDR_MODE, 32'({hs, pd, two}));
			bit_clks <= hs ? 16'h0008 : 16'h0020;
			repeat (2) begin
				d = $urandom & 32'h0000_01ff;
				f = frame(d[8:0], pd, two, n);
				nbits <= 5'(n);
				fq.push_back(f);
				wr(ADDR_TXDATA, d);
			end
			wait_tx;
		end
		wr(ADDR_MODE, 32'h0000_0000);
		bit_clks <= 16'h0020;
		nbits <= 5'h0e;
		fq.push_back(16'he000);
		wr(ADDR_STATUS, 32'h0000_0802);
		wait_tx;
		rd_chk(ADDR_STATUS, 32'h0000_0110);
		chk(32'(irq), 32'h0000_0000);
		wr(ADDR_IRQ_STAT, 32'h0000_0007);
		wr(ADDR_IRQ_MASK, 32'h0000_0001);
		// Line level flips at the same edge as the mode, so no false start
		wr(ADDR_MODE, 32'h0000_0016);
		inv <= 1'b1;
		d = $urandom & 32'h0000_01ff;
		f = frame(d[8:0], 2'b11, 1'b0, n);
		u_partner.send(f, n);
		wait_rx;
		chk(32'(irq), 32'h0000_0001);
		rd_chk(ADDR_RXDATA, d);
		wr(ADDR_IRQ_STAT, 32'h0000_0001);
		repeat (2) @(posedge i_sys_clk);
		chk(32'(irq), 32'h0000_0000);
		wr(ADDR_MODE, 32'h0000_0002);
		inv <= 1'b0;
		d = $urandom & 32'h0000_00ff;
		f = frame(d[8:0], 2'b01, 1'b0, n);
		u_partner.send(f, n);
		f = frame(~d[8:0], 2'b01, 1'b0, n);
		u_partner.send(f, n);
		repeat (4) @(posedge i_sys_clk);
		rd_chk(ADDR_STATUS, 32'h0000_0113);
		rd_chk(ADDR_RXDATA, d);
		wr(ADDR_STATUS, 32'h0000_0000);
		rd_chk(ADDR_STATUS, 32'h0000_0110);
		wr(ADDR_IRQ_MASK, 32'h0000_0000);
		repeat (3) @(posedge i_sys_clk);
		chk(32'(irq), 32'h0000_0000);
		finish_test;
	end
endmodule
